/* File: hdl/flash_poll_consts.svh */
// Purpose: Constants of the flash status polling controller
// Assumes: 20 MHz core clock, byte-wide flash data bus
// Notes: Bus timing figures are plain defaults, adjust to the part in use
`ifndef FLASH_POLL_CONSTS_SVH
`define FLASH_POLL_CONSTS_SVH

`define FP_CLK_NS 50
`define FP_ACCESS_NS 100
`define FP_WE_PULSE_NS 100
`define FP_RD_CYC ((`FP_ACCESS_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_WE_CYC ((`FP_WE_PULSE_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_SYNC_CYC 2
`define FP_RESET_CMD 8'hf0
`define FP_BIT_POLL 7
`define FP_BIT_TOGGLE 6
`define FP_BIT_TIMEOUT 5

`endif

/* File: hdl/flash_poll_pkg.sv */
// Purpose: Types of the flash status polling controller
// Assumes: Nothing beyond the constants header
// Notes: State and method types only, numbers live in the header
package flash_poll_pkg;
    typedef enum logic {METHOD_POLLING, METHOD_TOGGLE} poll_method_t;
    typedef enum {PS_IDLE, PS_RD_A, PS_RD_B, PS_VERIFY, PS_RESET_WR} poll_state_t;
    typedef enum {CYC_IDLE, CYC_STROBE, CYC_RECOVER} cyc_state_t;
endpackage : flash_poll_pkg

/* File: hdl/flash_cycle_if.sv */
// Purpose: Request path from the polling sequencer to the bus cycle engine
// Assumes: Request held until done
// Notes: Done is a one-cycle pulse with read data beside it
`timescale 1ns/1ps
interface flash_cycle_if #(parameter int AW = 21);
    logic req;
    logic write;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport ctrl(output req, write, addr, wdata, input done, rdata);
    modport eng(input req, write, addr, wdata, output done, rdata);
endinterface : flash_cycle_if

/* File: hdl/flash_bus_cycle.sv */
// Purpose: Runs single read or write strobe cycles on the flash pins
// Assumes: Flash data pin is asynchronous to core_clk
// Notes: Read strobe is stretched by the synchroniser latency
`timescale 1ns/1ps
`include "flash_poll_consts.svh"
module flash_bus_cycle import flash_poll_pkg::*; #(
    parameter int AW = 21
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Sequencer side
    flash_cycle_if.eng bus,
    // Flash pins
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [AW-1:0] flash_addr,
    input wire logic [7:0] data_bus_byte_in,
    output logic [7:0] data_bus_byte_out,
    output logic data_bus_byte_oe
);
    localparam logic [3:0] RD_LAST = 4'(`FP_RD_CYC + `FP_SYNC_CYC - 1);
    localparam logic [3:0] WE_LAST = 4'(`FP_WE_CYC - 1);

    cyc_state_t state;
    logic [3:0] cnt;
    logic is_write;
    logic [7:0] dq_meta;
    logic [7:0] dq_sync;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dq_meta <= 8'h00;
            dq_sync <= 8'h00;
        end else begin
            dq_meta <= data_bus_byte_in;
            dq_sync <= dq_meta;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= CYC_IDLE;
            cnt <= 4'h0;
            is_write <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_addr <= '0;
            data_bus_byte_out <= 8'h00;
            data_bus_byte_oe <= 1'b0;
            bus.done <= 1'b0;
            bus.rdata <= 8'h00;
        end else begin
            bus.done <= 1'b0;
            case (state)
                CYC_IDLE: begin
                    if (bus.req) begin
                        state <= CYC_STROBE;
                        is_write <= bus.write;
                        flash_addr <= bus.addr;
                        flash_ce_n <= 1'b0;
                        flash_oe_n <= bus.write;
                        flash_we_n <= !bus.write;
                        data_bus_byte_out <= bus.wdata;
                        data_bus_byte_oe <= bus.write;
                        cnt <= bus.write ? WE_LAST : RD_LAST;
                    end
                end
                CYC_STROBE: begin
                    if (cnt == 4'h0) begin
                        state <= CYC_RECOVER;
                        flash_ce_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        flash_we_n <= 1'b1;
                        bus.done <= 1'b1;
                        if (!is_write) begin
                            bus.rdata <= dq_sync;
                        end
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                CYC_RECOVER: begin
                    // Data held one cycle past the write strobe rise
                    data_bus_byte_oe <= 1'b0;
                    state <= CYC_IDLE;
                end
                default: begin
                    state <= CYC_IDLE;
                end
            endcase
        end
    end

    property p_read_strobe;
        @(posedge core_clk) disable iff (rst)
        $fell(flash_oe_n) |-> !flash_oe_n [*4] ##1 flash_oe_n;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("read strobe length wrong");

    property p_write_data;
        @(posedge core_clk) disable iff (rst)
        !flash_we_n |-> data_bus_byte_oe && flash_oe_n && !flash_ce_n;
    endproperty
    a_write_data: assert property (p_write_data) else $error("write strobe without driven data");
endmodule : flash_bus_cycle

/* File: hdl/flash_status_poller.sv */
// Purpose: Host-side sequencer that polls a NOR flash for program/erase completion
// Assumes: Caller supplies the address being programmed or inside an erased sector
// Notes: Polling and toggle methods, timeout recheck, reset command on failure
`timescale 1ns/1ps
`include "flash_poll_consts.svh"
module flash_status_poller import flash_poll_pkg::*; #(
    parameter int AW = 21
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // User command
    input wire logic start,
    input wire logic method,
    input wire logic [AW-1:0] poll_addr,
    input wire logic [7:0] expect_data,
    input wire logic abort,
    // User status
    output logic busy,
    output logic done,
    output logic pass,
    output logic fail,
    output logic [7:0] result_data,
    output logic device_ready,
    // Flash pins
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [AW-1:0] flash_addr,
    input wire logic [7:0] data_bus_byte_in,
    output logic [7:0] data_bus_byte_out,
    output logic data_bus_byte_oe,
    input wire logic ready_busy_open_drain
);
    flash_cycle_if #(.AW(AW)) bc();

    poll_state_t state;
    poll_method_t method_q;
    logic [AW-1:0] poll_addr_q;
    logic [7:0] expect_q;
    logic [7:0] first_read;
    logic rechecked;
    logic rb_meta;
    logic rb_sync;

    flash_bus_cycle #(.AW(AW)) u_cycle (
        .core_clk(core_clk),
        .rst(rst),
        .bus(bc),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n),
        .flash_addr(flash_addr),
        .data_bus_byte_in(data_bus_byte_in),
        .data_bus_byte_out(data_bus_byte_out),
        .data_bus_byte_oe(data_bus_byte_oe)
    );

    // Pin released high means ready or suspended
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rb_meta <= 1'b0;
            rb_sync <= 1'b0;
        end else begin
            rb_meta <= ready_busy_open_drain;
            rb_sync <= rb_meta;
        end
    end
    assign device_ready = rb_sync;

    assign bc.req = (state != PS_IDLE);
    assign bc.write = (state == PS_RESET_WR);
    assign bc.addr = poll_addr_q;
    assign bc.wdata = `FP_RESET_CMD;
    assign busy = (state != PS_IDLE);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            method_q <= METHOD_POLLING;
            poll_addr_q <= '0;
            expect_q <= 8'h00;
        end else if (state == PS_IDLE && start) begin
            method_q <= poll_method_t'(method);
            poll_addr_q <= poll_addr;
            expect_q <= expect_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= PS_IDLE;
            first_read <= 8'h00;
            rechecked <= 1'b0;
            done <= 1'b0;
            pass <= 1'b0;
            fail <= 1'b0;
            result_data <= 8'h00;
        end else begin
            done <= 1'b0;
            case (state)
                PS_IDLE: begin
                    if (start) begin
                        // Every start begins at the top of the algorithm
                        state <= PS_RD_A;
                        rechecked <= 1'b0;
                        pass <= 1'b0;
                        fail <= 1'b0;
                    end
                end
                PS_RD_A: begin
                    if (bc.done) begin
                        first_read <= bc.rdata;
                        if (method_q == METHOD_TOGGLE) begin
                            state <= PS_RD_B;
                        end else if (bc.rdata[`FP_BIT_POLL] == expect_q[`FP_BIT_POLL]) begin
                            // Upper bit may settle apart from the rest
                            state <= PS_VERIFY;
                        end else if (bc.rdata[`FP_BIT_TIMEOUT] && !rechecked) begin
                            rechecked <= 1'b1;
                        end else if (bc.rdata[`FP_BIT_TIMEOUT]) begin
                            state <= PS_RESET_WR;
                        end else if (abort) begin
                            state <= PS_IDLE;
                        end
                    end
                end
                PS_RD_B: begin
                    if (bc.done) begin
                        if (bc.rdata[`FP_BIT_TOGGLE] == first_read[`FP_BIT_TOGGLE]) begin
                            state <= PS_VERIFY;
                        end else if (bc.rdata[`FP_BIT_TIMEOUT] && !rechecked) begin
                            // Toggling may have stopped just as timeout rose
                            rechecked <= 1'b1;
                            state <= PS_RD_A;
                        end else if (bc.rdata[`FP_BIT_TIMEOUT]) begin
                            state <= PS_RESET_WR;
                        end else if (abort) begin
                            state <= PS_IDLE;
                        end else begin
                            state <= PS_RD_A;
                        end
                    end
                end
                PS_VERIFY: begin
                    if (bc.done) begin
                        result_data <= bc.rdata;
                        pass <= 1'b1;
                        done <= 1'b1;
                        state <= PS_IDLE;
                    end
                end
                PS_RESET_WR: begin
                    if (bc.done) begin
                        fail <= 1'b1;
                        done <= 1'b1;
                        state <= PS_IDLE;
                    end
                end
                default: begin
                    state <= PS_IDLE;
                end
            endcase
        end
    end

    property p_poll_addr;
        @(posedge core_clk) disable iff (rst)
        bc.req && !bc.write |-> flash_ce_n || flash_addr == poll_addr_q;
    endproperty
    a_poll_addr: assert property (p_poll_addr) else $error("status read away from poll address");

    property p_erase_addr;
        @(posedge core_clk) disable iff (rst)
        !flash_oe_n |-> flash_addr == poll_addr_q;
    endproperty
    a_erase_addr: assert property (p_erase_addr) else $error("read strobe at wrong address");

    property p_next_read_data;
        @(posedge core_clk) disable iff (rst)
        state == PS_VERIFY && bc.done |=> done && pass && result_data == $past(bc.rdata);
    endproperty
    a_next_read_data: assert property (p_next_read_data) else $error("result not from following read");

    property p_recheck_timeout;
        @(posedge core_clk) disable iff (rst)
        $rose(state == PS_RESET_WR) |-> rechecked;
    endproperty
    a_recheck_timeout: assert property (p_recheck_timeout) else $error("failure without recheck");

    property p_toggle_compare;
        @(posedge core_clk) disable iff (rst)
        state == PS_RD_B && bc.done && bc.rdata[`FP_BIT_TOGGLE] == first_read[`FP_BIT_TOGGLE] |=> state == PS_VERIFY;
    endproperty
    a_toggle_compare: assert property (p_toggle_compare) else $error("equal toggle reads not finished");

    property p_array_read_follows;
        @(posedge core_clk) disable iff (rst)
        $rose(state == PS_VERIFY) |-> ##[1:3] !flash_oe_n;
    endproperty
    a_array_read_follows: assert property (p_array_read_follows) else $error("no read after completion");

    property p_reset_command;
        @(posedge core_clk) disable iff (rst)
        done && fail |-> $past(state == PS_RESET_WR) && !pass;
    endproperty
    a_reset_command: assert property (p_reset_command) else $error("failure without reset command");

    property p_reset_data;
        @(posedge core_clk) disable iff (rst)
        !flash_we_n |-> data_bus_byte_out == `FP_RESET_CMD && data_bus_byte_oe;
    endproperty
    a_reset_data: assert property (p_reset_data) else $error("reset command data wrong");

    property p_restart;
        @(posedge core_clk) disable iff (rst)
        state == PS_IDLE && start |=> state == PS_RD_A && !rechecked && !pass && !fail;
    endproperty
    a_restart: assert property (p_restart) else $error("polling not restarted from top");

    c_pass_polling: cover property (@(posedge core_clk) disable iff (rst) done && pass && method_q == METHOD_POLLING);
    c_pass_toggle: cover property (@(posedge core_clk) disable iff (rst) done && pass && method_q == METHOD_TOGGLE);
    c_fail: cover property (@(posedge core_clk) disable iff (rst) done && fail);
    c_abort: cover property (@(posedge core_clk) disable iff (rst) busy && abort ##1 !busy && !done);
endmodule : flash_status_poller

/* File: testbench/flash_dev_model.sv */
// Purpose: Behavioural flash device answering status reads and write cycles
// Assumes: Bench pulses launch to stand for the final write strobe of a command
// Notes: Busy length counted in status reads, 8'hff means the routine never ends
`timescale 1ns/1ps
module flash_dev_model (
    // Host strobes and buses
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] host_data,
    input wire logic host_data_oe,
    output logic [7:0] dev_data,
    output logic rb_low,
    // Bench control
    input wire logic launch,
    input wire logic op_erase,
    input wire logic [7:0] prog_byte,
    input wire logic [7:0] array_byte,
    input wire logic [7:0] busy_reads,
    input wire logic [7:0] to_reads,
    output logic [7:0] wr_last
);
    logic [7:0] cnt = 8'h00;
    logic [7:0] idx = 8'h00;
    logic [7:0] last = 8'h00;
    logic run = 1'b0;
    logic tog1 = 1'b0;
    logic tog2 = 1'b0;
    logic settle = 1'b0;
    logic to_hit;
    wire logic rd_n = ce_n | oe_n;
    wire logic wr_n = ce_n | we_n;

    initial wr_last = 8'h00;
    assign to_hit = (idx >= to_reads);
    // Released bus shows the inverse so a stale value cannot pass
    assign dev_data = rd_n ? ~last : last;
    assign rb_low = run;

    always @(posedge launch) begin
        run = 1'b1;
        cnt = busy_reads;
        idx = 8'h00;
        tog1 = 1'b0;
        settle = 1'b0;
    end

    always @(negedge rd_n) begin
        if (run) begin
            tog1 = ~tog1;
            tog2 = ~tog2;
            if (op_erase)
                last = {1'b0, tog1, to_hit, 2'b01, tog2, 2'b00};
            else
                last = {~prog_byte[7], tog1, to_hit, prog_byte[4:0]};
            idx = idx + 8'h01;
            if (cnt != 8'hff)
                cnt = cnt - 8'h01;
            if (cnt == 8'h00) begin
                run = 1'b0;
                settle = 1'b1;
            end
        end else if (settle) begin
            // Upper bit turns true ahead of the lower bits
            last = {array_byte[7], ~array_byte[6:0]};
            settle = 1'b0;
        end else begin
            // Protected sectors keep their contents after an erase
            last = array_byte;
        end
    end

    always @(posedge wr_n) begin
        if (host_data_oe) begin
            wr_last = host_data;
            // Reset command drops status back to array reads
            if (host_data == 8'hf0) begin
                run = 1'b0;
                settle = 1'b0;
            end
        end
    end
endmodule : flash_dev_model

/* File: testbench/tb.sv */
// Purpose: Self-checking bench of the flash status poller
// Assumes: Open-drain busy pin has a pull-up on the board
// Notes: Each run launches a device routine then polls it to a verdict
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic method = 1'b0;
    logic abort = 1'b0;
    logic [20:0] poll_addr = 21'h01a2b4;
    logic [7:0] expect_data = 8'h00;
    logic busy, done, pass, fail, device_ready, ce_n, oe_n, we_n, dq_oe, rb_low;
    logic [7:0] result_data, dq_out, dq_in, wr_last;
    logic [20:0] flash_addr;
    logic launch = 1'b0;
    logic op_erase = 1'b0;
    logic [7:0] prog_byte = 8'h00;
    logic [7:0] array_byte = 8'h00;
    logic [7:0] busy_reads = 8'h00;
    logic [7:0] to_reads = 8'hff;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    int dones = 0;
    logic [20:0] rd_addr = 21'h000000;
    wire logic rb_pin = rb_low ? 1'b0 : 1'b1;

    always #25 core_clk = ~core_clk;

    // Address seen while the read strobe is low
    always @(posedge core_clk)
        if (oe_n === 1'b0)
            rd_addr <= flash_addr;

    flash_status_poller i_dut (.core_clk(core_clk), .rst(rst), .start(start), .method(method),
        .poll_addr(poll_addr), .expect_data(expect_data), .abort(abort), .busy(busy), .done(done),
        .pass(pass), .fail(fail), .result_data(result_data), .device_ready(device_ready),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(flash_addr),
        .data_bus_byte_in(dq_in), .data_bus_byte_out(dq_out), .data_bus_byte_oe(dq_oe),
        .ready_busy_open_drain(rb_pin));

    flash_dev_model i_dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .host_data(dq_out),
        .host_data_oe(dq_oe), .dev_data(dq_in), .rb_low(rb_low), .launch(launch),
        .op_erase(op_erase), .prog_byte(prog_byte), .array_byte(array_byte),
        .busy_reads(busy_reads), .to_reads(to_reads), .wr_last(wr_last));

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    always @(posedge core_clk) begin
        cycles++;
        if (done === 1'b1)
            dones++;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end

    task automatic launch_op(input logic m, input logic er, input logic [7:0] pb, arr, br, tr);
        @(negedge core_clk);
        method = m;
        op_erase = er;
        prog_byte = pb;
        array_byte = arr;
        busy_reads = br;
        to_reads = tr;
        expect_data = er ? 8'hff : pb;
        launch = 1'b1;
        @(negedge core_clk);
        launch = 1'b0;
        repeat (3) @(negedge core_clk);
        check(device_ready, 1'b0, "busy pin");
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
    endtask : launch_op

    task automatic run(input logic m, input logic er, input logic [7:0] pb, arr, br, tr, input logic ok);
        int n;
        n = 0;
        launch_op(m, er, pb, arr, br, tr);
        while (done !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check(n < 400, 1'b1, "done seen");
        check(rd_addr, poll_addr, "read address");
        check(pass, ok, "pass flag");
        check(fail, !ok, "fail flag");
        if (ok)
            check(result_data, arr, "result data");
        else
            check(wr_last, 8'hf0, "reset command");
        repeat (3) @(negedge core_clk);
        check(device_ready, 1'b1, "ready pin");
    endtask : run

    initial begin
        int d0;
        int n;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        // Polling: plain program, erase, timeout with late success, failure
        run(1'b0, 1'b0, 8'h5a, 8'h5a, 8'h03, 8'hff, 1'b1);
        run(1'b0, 1'b1, 8'hff, 8'hff, 8'h04, 8'hff, 1'b1);
        run(1'b0, 1'b0, 8'h3c, 8'h3c, 8'h03, 8'h02, 1'b1);
        run(1'b0, 1'b0, 8'ha5, 8'h25, 8'hff, 8'h02, 1'b0);
        // Toggle: plain erase, protected sector kept, timeout with late success, failure
        run(1'b1, 1'b1, 8'hff, 8'hff, 8'h04, 8'hff, 1'b1);
        run(1'b1, 1'b1, 8'hff, 8'h3c, 8'h03, 8'hff, 1'b1);
        run(1'b1, 1'b0, 8'h81, 8'h81, 8'h04, 8'h03, 1'b1);
        run(1'b1, 1'b1, 8'hff, 8'hff, 8'hff, 8'h01, 1'b0);
        // Abort mid-poll gives no verdict, a fresh poll then completes
        d0 = dones;
        launch_op(1'b1, 1'b1, 8'hff, 8'hff, 8'hff, 8'hff);
        repeat (40) @(negedge core_clk);
        abort = 1'b1;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        abort = 1'b0;
        check(busy, 1'b0, "abort idle");
        check(dones == d0, 1'b1, "no done on abort");
        // New address must be taken with the fresh start
        poll_addr = 21'h0f0e1c;
        run(1'b0, 1'b0, 8'h77, 8'h77, 8'h02, 8'hff, 1'b1);
        close_out();
    end
endmodule : tb
